/* word_rotate_mask_unit.sv */
// What this block does
// - Opcode 20 is insert form; mask end at 21-25, begin at 26-30.
// - Opcode 21 is AND form; mask begin at 21-25, end at 26-30.
// - Source word rotates left by the immediate amount before masking.
// - Insert form takes rotated bits under mask ones, keeps old bits elsewhere.
// - AND form gives rotated word ANDed with the mask.
// - Begin below end plus one gives ones from begin through end.
// - Begin equal to end plus one gives an all-ones mask.
// - Begin above end plus one zeroes end+1 through begin-1 only.
// - Record bit set updates the four flags; clear leaves them alone.
// - No form ever touches overflow or the exception state.
`timescale 1ns/1ns
module word_rotate_mask_unit
(
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [rotmask_pkg::ADDR_W-1:0] paddr,
	input  wire logic [rotmask_pkg::DATA_W-1:0] pwdata,
	input  wire logic [rotmask_pkg::STRB_W-1:0] pstrb,
	output logic      [rotmask_pkg::DATA_W-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Write-back towards the register file
	output logic                            wb_valid,
	output logic      [rotmask_pkg::IDX_W-1:0]  wb_dest_idx,
	output logic      [rotmask_pkg::DATA_W-1:0] wb_data,
	// Condition field 0
	output logic                            negative_flag,
	output logic                            positive_flag,
	output logic                            zero_flag,
	output logic                            summary_overflow_flag
);
	import rotmask_pkg::*;

	// Byte-lane merge for partial writes
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// Software-visible state
	logic [DATA_W-1:0] instr_q;
	logic [DATA_W-1:0] src_q;
	logic [DATA_W-1:0] dst_q;
	logic              sovf_q;
	logic [DATA_W-1:0] result_q;
	logic [3:0]        cr0_q;
	logic              done_q;
	logic              illegal_q;
	logic [DATA_W-1:0] count_q;

	// Bus answer and write-back state
	logic [DATA_W-1:0] prdata_q;
	logic              err_q;
	logic              wb_valid_q;
	logic [IDX_W-1:0]  wb_idx_q;

	// Bus phase decode
	logic setup_ph;
	logic access_ph;
	logic wr_acc;

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_acc    = access_ph & pwrite;

	// Address decode
	logic hit_instr;
	logic hit_src;
	logic hit_dst;
	logic hit_sovf;
	logic hit_ctrl;
	logic hit_result;
	logic hit_cr0;
	logic hit_status;
	logic hit_count;
	logic hit_any;

	assign hit_instr  = paddr == OFS_INSTR;
	assign hit_src    = paddr == OFS_SRC;
	assign hit_dst    = paddr == OFS_DST;
	assign hit_sovf   = paddr == OFS_SOVF;
	assign hit_ctrl   = paddr == OFS_CTRL;
	assign hit_result = paddr == OFS_RESULT;
	assign hit_cr0    = paddr == OFS_CR0;
	assign hit_status = paddr == OFS_STATUS;
	assign hit_count  = paddr == OFS_COUNT;
	assign hit_any    = hit_instr | hit_src | hit_dst | hit_sovf
		| hit_ctrl | hit_result | hit_cr0 | hit_status | hit_count;

	// Write strobes per register
	logic wr_instr;
	logic wr_src;
	logic wr_dst;
	logic wr_sovf;
	logic wr_status;
	logic go;

	assign wr_instr  = wr_acc & hit_instr;
	assign wr_src    = wr_acc & hit_src;
	assign wr_dst    = wr_acc & hit_dst;
	assign wr_sovf   = wr_acc & hit_sovf & pstrb[0];
	assign wr_status = wr_acc & hit_status & pstrb[0];
	assign go        = wr_acc & hit_ctrl & pstrb[0] & pwdata[CTRL_GO];

	// Instruction fields, position 0 is the top bit
	logic [OP_W-1:0]  opcode;
	logic [IDX_W-1:0] source_reg;
	logic [IDX_W-1:0] dest_reg;
	logic [IDX_W-1:0] rotate_amount;
	logic [IDX_W-1:0] field_a;
	logic [IDX_W-1:0] field_b;
	logic             record_bit;

	assign opcode        = instr_q[F_OPC_LO +: OP_W];
	assign source_reg    = instr_q[F_SRC_LO +: IDX_W];
	assign dest_reg      = instr_q[F_DST_LO +: IDX_W];
	assign rotate_amount = instr_q[F_ROT_LO +: IDX_W];
	assign field_a       = instr_q[F_A_LO +: IDX_W];
	assign field_b       = instr_q[F_B_LO +: IDX_W];
	assign record_bit    = instr_q[F_REC];

	// Form selection
	logic is_insert;
	logic is_and;
	logic legal;

	assign is_insert = opcode == OPC_INSERT;
	assign is_and    = opcode == OPC_AND;
	assign legal     = is_insert | is_and;

	// Only a legal execute updates results, flags and counters
	logic exec_ok;

	assign exec_ok = go & legal;

	// The insert form prints its bounds in swapped slots
	logic [IDX_W-1:0] mask_begin;
	logic [IDX_W-1:0] mask_end;

	assign mask_begin = is_insert ? field_b : field_a;
	assign mask_end   = is_insert ? field_a : field_b;

	// Rotate and mask datapath
	logic [DATA_W-1:0] rotated;
	logic [DATA_W-1:0] mask;

	word_rotator u_rot (
		.data_in  (src_q),
		.amount   (rotate_amount),
		.data_out (rotated)
	);

	mask_builder u_mask (
		.mask_begin (mask_begin),
		.mask_end   (mask_end),
		.mask       (mask)
	);

	// Result of either form
	logic [DATA_W-1:0] and_res;
	logic [DATA_W-1:0] ins_res;
	logic [DATA_W-1:0] result;

	assign and_res = rotated & mask;
	assign ins_res = and_res | (dst_q & ~mask);
	assign result  = is_insert ? ins_res : and_res;

	// Condition flags from a signed compare against zero
	logic       res_zero;
	logic       res_neg;
	logic [3:0] cr0_new;

	assign res_zero = result == RST_WORD;
	assign res_neg  = result[DATA_W-1];
	assign cr0_new[CR_NEG]  = res_neg;
	assign cr0_new[CR_POS]  = ~res_neg & ~res_zero;
	assign cr0_new[CR_ZERO] = res_zero;
	assign cr0_new[CR_SO]   = sovf_q;

	// Operand registers; the destination mirrors the last result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_q <= RST_WORD;
			src_q   <= RST_WORD;
			dst_q   <= RST_WORD;
		end else begin
			if (wr_instr) begin
				instr_q <= merge(instr_q, pwdata, pstrb);
			end
			if (wr_src) begin
				src_q <= merge(src_q, pwdata, pstrb);
			end
			if (wr_dst) begin
				dst_q <= merge(dst_q, pwdata, pstrb);
			end else if (exec_ok) begin
				dst_q <= result;
			end
		end
	end

	// Summary overflow is software state; execution never writes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sovf_q <= RST_BIT;
		end else if (wr_sovf) begin
			sovf_q <= pwdata[0];
		end
	end

	// Condition field refreshes only on a recorded execute
	logic [3:0] cr0_d;

	assign cr0_d = (exec_ok & record_bit) ? cr0_new : cr0_q;

	// Result and condition field capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= RST_WORD;
			cr0_q    <= RST_CR0;
		end else begin
			cr0_q <= cr0_d;
			if (exec_ok) begin
				result_q <= result;
			end
		end
	end

	// Write-one-to-clear requests for the sticky bits
	logic clr_done;
	logic clr_illegal;

	assign clr_done    = wr_status & pwdata[ST_DONE];
	assign clr_illegal = wr_status & pwdata[ST_ILLEGAL];

	// Sticky status, cleared by writing ones; a new event wins
	logic done_d;
	logic illegal_d;

	assign done_d    = exec_ok | (done_q & ~clr_done);
	assign illegal_d = (go & ~legal) | (illegal_q & ~clr_illegal);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q    <= RST_BIT;
			illegal_q <= RST_BIT;
		end else begin
			done_q    <= done_d;
			illegal_q <= illegal_d;
		end
	end

	// Count of executed legal operations
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= RST_WORD;
		end else if (exec_ok) begin
			count_q <= count_q + 32'h0000_0001;
		end
	end

	// Write-back pulse one cycle after a legal execute
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_valid_q <= RST_BIT;
			wb_idx_q   <= '0;
		end else begin
			wb_valid_q <= exec_ok;
			if (exec_ok) begin
				wb_idx_q <= dest_reg;
			end
		end
	end

	// Status word: sticky bits low, live decode of the operand indexes above
	logic [DATA_W-1:0] status_w;

	always_comb begin
		status_w                     = RST_WORD;
		status_w[ST_DONE]            = done_q;
		status_w[ST_ILLEGAL]         = illegal_q;
		status_w[ST_INSERT]          = is_insert;
		status_w[ST_RECORD]          = record_bit;
		status_w[ST_DST_LO +: IDX_W] = dest_reg;
		status_w[ST_SRC_LO +: IDX_W] = source_reg;
	end

	// Read mux
	logic [DATA_W-1:0] rd_mux;

	assign rd_mux =
		hit_instr  ? instr_q :
		hit_src    ? src_q :
		hit_dst    ? dst_q :
		hit_sovf   ? {31'h0000_0000, sovf_q} :
		hit_result ? result_q :
		hit_cr0    ? {28'h000_0000, cr0_q} :
		hit_status ? status_w :
		hit_count  ? count_q :
		RST_WORD;

	// Answer prepared in the setup cycle, shown in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= RST_WORD;
			err_q    <= RST_BIT;
		end else if (setup_ph) begin
			prdata_q <= pwrite ? RST_WORD : rd_mux;
			err_q    <= ~hit_any;
		end
	end

	// Bus outputs; zero wait states
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = access_ph & err_q;

	// Write-back and flag outputs
	assign wb_valid              = wb_valid_q;
	assign wb_dest_idx           = wb_idx_q;
	assign wb_data               = result_q;
	assign negative_flag         = cr0_q[CR_NEG];
	assign positive_flag         = cr0_q[CR_POS];
	assign zero_flag             = cr0_q[CR_ZERO];
	assign summary_overflow_flag = cr0_q[CR_SO];

endmodule : word_rotate_mask_unit

/* rotmask_pkg.sv */
// Shared constants for the word rotate-and-mask unit
package rotmask_pkg;

	// Datapath widths
	localparam int DATA_W = 32;
	localparam int IDX_W  = 5;
	localparam int OP_W   = 6;
	localparam int ADDR_W = 8;
	localparam int STRB_W = 4;

	// Primary opcodes of the two immediate forms
	localparam logic [OP_W-1:0] OPC_INSERT = 6'h14;
	localparam logic [OP_W-1:0] OPC_AND    = 6'h15;

	// Field low bits in the instruction word (position 0 is bit 31)
	localparam int F_OPC_LO = 26;
	localparam int F_SRC_LO = 21;
	localparam int F_DST_LO = 16;
	localparam int F_ROT_LO = 11;
	localparam int F_A_LO   = 6;
	localparam int F_B_LO   = 1;
	localparam int F_REC    = 0;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_INSTR  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SRC    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DST    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SOVF   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CR0    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h20;

	// Bit positions inside control, status and flag registers
	localparam int CTRL_GO    = 0;
	localparam int ST_DONE    = 0;
	localparam int ST_ILLEGAL = 1;
	localparam int ST_INSERT  = 2;
	localparam int ST_RECORD  = 3;
	localparam int ST_DST_LO  = 16;
	localparam int ST_SRC_LO  = 24;
	localparam int CR_SO      = 0;
	localparam int CR_ZERO    = 1;
	localparam int CR_POS     = 2;
	localparam int CR_NEG     = 3;

	// Reset values
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0]        RST_CR0  = 4'h0;
	localparam logic              RST_BIT  = 1'b0;

endpackage : rotmask_pkg

/* word_rotator.sv */
// Circular left rotate of a 32-bit word by an immediate amount
`timescale 1ns/1ns
module word_rotator
(
	// Operand
	input  wire logic [rotmask_pkg::DATA_W-1:0] data_in,
	input  wire logic [rotmask_pkg::IDX_W-1:0]  amount,
	// Rotated word
	output logic      [rotmask_pkg::DATA_W-1:0] data_out
);
	import rotmask_pkg::*;

	logic [2*DATA_W-1:0] doubled;
	logic [2*DATA_W-1:0] shifted;

	// Bits leaving the top re-enter at the bottom
	assign doubled  = {data_in, data_in};
	assign shifted  = doubled << amount;
	assign data_out = shifted[2*DATA_W-1:DATA_W];

endmodule : word_rotator

/* mask_builder.sv */
// Builds the 32-bit begin/end mask, wrapping when begin passes end
`timescale 1ns/1ns
module mask_builder
(
	// Mask bounds, position 0 is the most significant bit
	input  wire logic [rotmask_pkg::IDX_W-1:0]  mask_begin,
	input  wire logic [rotmask_pkg::IDX_W-1:0]  mask_end,
	// Generated mask
	output logic      [rotmask_pkg::DATA_W-1:0] mask
);
	import rotmask_pkg::*;

	logic [IDX_W:0] begin_w;
	logic [IDX_W:0] end_p1;
	logic           wrapped;

	assign begin_w = {1'b0, mask_begin};
	assign end_p1  = {1'b0, mask_end} + 6'h01;
	assign wrapped = begin_w >= end_p1;

	// One term per position; begin just past end gives all ones through the wrap form
	for (genvar p = 0; p < DATA_W; p++) begin : g_bit
		localparam logic [IDX_W-1:0] POS = IDX_W'(p);
		assign mask[DATA_W-1-p] = wrapped ?
			(POS <= mask_end) || (POS >= mask_begin) :
			(POS >= mask_begin) && (POS <= mask_end);
	end

endmodule : mask_builder

/* rotmask_chk.sv */
// Port checker for the rotate-and-mask unit, bound to its top module
`timescale 1ns/1ns
module rotmask_chk
	import rotmask_pkg::*;
(
	// Clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	// APB
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [rotmask_pkg::ADDR_W-1:0] paddr,
	input wire logic [rotmask_pkg::DATA_W-1:0] pwdata,
	input wire logic [rotmask_pkg::STRB_W-1:0] pstrb,
	input wire logic                     pslverr,
	// Write-back and flags
	input wire logic                     wb_valid,
	input wire logic [rotmask_pkg::IDX_W-1:0]  wb_dest_idx,
	input wire logic [rotmask_pkg::DATA_W-1:0] wb_data,
	input wire logic                     negative_flag,
	input wire logic                     positive_flag,
	input wire logic                     zero_flag,
	input wire logic                     summary_overflow_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Execute strobe and flag group
	wire       go = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[0] && pstrb[0];
	wire [3:0] cr = {negative_flag, positive_flag, zero_flag, summary_overflow_flag};
	wb_cause_a: assert property (wb_valid |-> $past(go))
		else $error("write-back without execute");
	wb_pulse_a: assert property (wb_valid |=> !wb_valid)
		else $error("write-back pulse too long");
	wb_hold_a: assert property (!wb_valid |-> $stable(wb_data) && $stable(wb_dest_idx))
		else $error("result moved without write-back");
	flag_hold_a: assert property (cr[3:1] != $past(cr[3:1]) |-> wb_valid)
		else $error("flags moved without execute");
	so_hold_a: assert property ($changed(summary_overflow_flag) |-> wb_valid)
		else $error("overflow flag moved without execute");
	flag_sign_a: assert property (wb_valid && cr != $past(cr) |->
		negative_flag == wb_data[31] && zero_flag == (wb_data == 32'h0000_0000))
		else $error("sign or zero flag wrong");
	flag_pos_a: assert property (wb_valid && cr != $past(cr) |->
		positive_flag == !(wb_data[31] || wb_data == 32'h0000_0000))
		else $error("positive flag wrong");
	flag_one_a: assert property ($onehot0(cr[3:1]))
		else $error("more than one compare flag");
	// Main scenarios
	cover property (wb_valid && zero_flag);
	cover property (wb_valid && negative_flag);
	cover property (psel && penable && pslverr);
endmodule : rotmask_chk

bind word_rotate_mask_unit rotmask_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pslverr, .wb_valid, .wb_dest_idx, .wb_data,
	.negative_flag, .positive_flag, .zero_flag, .summary_overflow_flag);

/* regfile_model.sv */
// Register-file model that takes the unit's write-backs
`timescale 1ns/1ns
module regfile_model
	import rotmask_pkg::*;
(
	// Clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	// Write-back
	input wire logic                     wb_valid,
	input wire logic [rotmask_pkg::IDX_W-1:0]  wb_dest_idx,
	input wire logic [rotmask_pkg::DATA_W-1:0] wb_data
);
	logic [DATA_W-1:0] regs [32];
	int                wr_cnt;
	// One register write for each write-back pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_cnt <= 0;
		end else if (wb_valid) begin
			regs[wb_dest_idx] <= wb_data;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule : regfile_model

/* tb.sv */
// Self-checking bench for the rotate-and-mask unit
`timescale 1ns/1ns
module tb;
	import rotmask_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
	logic        wb_valid, negative_flag, positive_flag, zero_flag, summary_overflow_flag;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, wb_data, rd_q, res_last;
	logic [4:0]  wb_dest_idx;
	logic [3:0]  cr_e;
	int          n_fail, checks_done;
	word_rotate_mask_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .wb_valid, .wb_dest_idx, .wb_data,
		.negative_flag, .positive_flag, .zero_flag, .summary_overflow_flag);
	regfile_model rf (.pclk, .presetn, .wb_valid, .wb_dest_idx, .wb_data);
	// Clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task close_out;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Reference rotate and mask, position 0 is the MSB
	function automatic logic [31:0] rot(input logic [31:0] x, input logic [4:0] n);
		logic [63:0] t;
		t = {x, x} << n;
		return t[63:32];
	endfunction : rot
	function automatic logic [31:0] mask(input logic [4:0] b, input logic [4:0] e);
		logic [31:0] m;
		for (int p = 0; p < 32; p++) m[31-p] = (b <= e) ? (p >= b && p <= e) : (p >= b || p <= e);
		return m;
	endfunction : mask
	// Loads operands, executes, judges result, flags and write-back
	task exec(input logic ins, rec, input logic [4:0] sh, mb, me, input logic [31:0] s, dv, so);
		logic [31:0] m;
		int          n;
		m = mask(mb, me);
		res_last = ins ? (rot(s, sh) & m) | (dv & ~m) : rot(s, sh) & m;
		n = rf.wr_cnt;
		if (rec) cr_e = {res_last[31], !res_last[31] && |res_last, ~|res_last, so[0]};
		apb(1'b1, OFS_SOVF, so);
		apb(1'b1, OFS_SRC, s);
		apb(1'b1, OFS_DST, dv);
		apb(1'b1, OFS_INSTR, {ins ? OPC_INSERT : OPC_AND, 5'h04, 5'h06, sh,
			ins ? me : mb, ins ? mb : me, rec});
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b0, OFS_RESULT, 32'h0000_0000);
		chk(rd_q, res_last);
		apb(1'b0, OFS_CR0, 32'h0000_0000);
		chk(rd_q[3:0], cr_e);
		chk({negative_flag, positive_flag, zero_flag, summary_overflow_flag}, cr_e);
		chk(rf.regs[6], res_last);
		chk(rf.wr_cnt - n, 32'h0000_0001);
		chk(wb_dest_idx, 5'h06);
	endtask : exec
	task t_examples;
		exec(1'b1, 1'b0, 5'h02, 5'h00, 5'h1D, 32'h9000_3000, 32'h0000_0003, 32'h0000_0000);
		chk(rf.regs[6], 32'h4000_C003);
		exec(1'b1, 1'b1, 5'h02, 5'h00, 5'h1A, 32'h789A_789B, 32'h3000_0003, 32'h0000_0000);
		chk(rf.regs[6], 32'hE269_E263);
		exec(1'b0, 1'b1, 5'h02, 5'h00, 5'h1D, 32'hB004_3000, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(rf.regs[6], 32'hC010_C000);
		chk(cr_e, 4'h8);
	endtask : t_examples
	task t_masks;
		exec(1'b0, 1'b0, 5'h00, 5'h03, 5'h07, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
		chk(rf.regs[6], 32'h1F00_0000);
		exec(1'b0, 1'b0, 5'h00, 5'h08, 5'h07, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
		chk(rf.regs[6], 32'hFFFF_FFFF);
		exec(1'b0, 1'b0, 5'h00, 5'h09, 5'h07, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
		chk(rf.regs[6], 32'hFF7F_FFFF);
		exec(1'b0, 1'b0, 5'h00, 5'h00, 5'h1F, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
		exec(1'b0, 1'b0, 5'h00, 5'h1F, 5'h00, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
		chk(rf.regs[6], 32'h8000_0001);
		exec(1'b0, 1'b0, 5'h00, 5'h05, 5'h05, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
		chk(rf.regs[6], 32'h0400_0000);
		for (int i = 1; i < 32; i += 10) exec(1'b0, 1'b0, 5'(i), 5'h00, 5'h1F, 32'h8000_0001,
			32'h0000_0000, 32'h0000_0000);
		chk(rf.regs[6], 32'hC000_0000);
		exec(1'b1, 1'b0, 5'h0B, 5'h1C, 5'h03, 32'h1234_5678, 32'hA5A5_A5A5, 32'h0000_0000);
		chk(rf.regs[6], 32'hA5A5_A5A1);
	endtask : t_masks
	task t_record;
		exec(1'b0, 1'b1, 5'h00, 5'h00, 5'h1F, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001);
		chk(cr_e, 4'h3);
		exec(1'b0, 1'b0, 5'h00, 5'h00, 5'h1F, 32'h7000_0000, 32'h0000_0000, 32'h0000_0000);
		exec(1'b0, 1'b1, 5'h00, 5'h00, 5'h1F, 32'h7000_0000, 32'h0000_0000, 32'h0000_0000);
	endtask : t_record
	task t_illegal;
		int n;
		n = rf.wr_cnt;
		apb(1'b1, OFS_INSTR, 32'h5800_0001);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b0, OFS_RESULT, 32'h0000_0000);
		chk(rd_q, res_last);
		chk(rf.wr_cnt - n, 32'h0000_0000);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd_q[ST_ILLEGAL], 1'b1);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk(rd_q, 32'h0000_0000);
		chk({31'h0000_0000, err_q}, 32'h0000_0001);
	endtask : t_illegal
	// Reset, then the scenarios
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		cr_e = 4'h0;
		n_fail = 0;
		checks_done = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_examples;
		t_masks;
		t_record;
		t_illegal;
		close_out;
	end
	// Watchdog
	initial begin
		#40000;
		n_fail++;
		close_out;
	end
endmodule : tb
